/* File: src/pil_pkg.sv */
// constants and types for the program level interrupt control block
package pil_pkg;

	// operation codes from the instruction sequencer
	localparam logic [2:0] OP_NONE  = 3'h0;
	localparam logic [2:0] OP_SET   = 3'h1;
	localparam logic [2:0] OP_CLEAR = 3'h2;
	localparam logic [2:0] OP_WRITE = 3'h3;
	localparam logic [2:0] OP_READ  = 3'h4;
	localparam logic [2:0] OP_WAIT  = 3'h5;
	localparam logic [2:0] OP_ION   = 3'h6;
	localparam logic [2:0] OP_IOF   = 3'h7;

	// register selects
	localparam logic [2:0] SEL_REQUEST = 3'h0;
	localparam logic [2:0] SEL_ENABLE  = 3'h1;
	localparam logic [2:0] SEL_SOURCE  = 3'h2;
	localparam logic [2:0] SEL_CAUSE   = 3'h3;
	localparam logic [2:0] SEL_PREV    = 3'h4;

	// masks and fixed levels
	localparam logic [15:0] EXT_REQ_MASK  = 16'hbc00;
	localparam logic [10:0] SRC_MASK      = 11'h7fe;
	localparam logic [3:0]  LVL_INTERNAL  = 4'he;
	localparam logic [3:0]  LVL_TOP       = 4'hf;
	localparam logic [3:0]  LVL_ZERO      = 4'h0;

	// source bit positions and the low bit of the previous level field in a read
	localparam int SRC_PROTECT  = 2;
	localparam int SRC_PAGE     = 3;
	localparam int SRC_NOADDR   = 9;
	localparam int SRC_POWER    = 10;
	localparam int PREV_LSB     = 3;

	// inter-register read code around the level field (arbitrary value)
	localparam logic [15:0] IRR_BASE = 16'h0000;

	// reset values
	localparam logic [15:0] RST_REQ    = 16'h0000;
	localparam logic [15:0] RST_ENA    = 16'h0000;
	localparam logic [10:0] RST_SRC    = 11'h000;
	localparam logic [3:0]  RST_CAUSE  = 4'h0;
	localparam logic [3:0]  RST_LEVEL  = 4'h0;

	// context switch time
	localparam int SWITCH_NS = 1000;
	localparam int CLK_NS    = 25;
	localparam logic [5:0] SWITCH_CYC =
		6'((SWITCH_NS + CLK_NS - 1) / CLK_NS);

	typedef enum logic [1:0] {
		ST_RUN    = 2'b01,
		ST_SWITCH = 2'b10
	} pil_state_t;

endpackage : pil_pkg

/* File: src/pil_prio_enc.sv */
// highest set bit finder
`timescale 1ns/1ps
module pil_prio_enc #(
	parameter int W = 16
) (
	// request vector
	input  wire logic [W-1:0] vec,
	// result
	output logic              any,
	output logic [3:0]        idx
);
	always_comb begin
		any = 1'b0;
		idx = 4'h0;
		for (int i = 0; i < W; i++) begin
			if (vec[i]) begin
				any = 1'b1;
				idx = 4'(i);
			end
		end
	end
endmodule : pil_prio_enc

/* File: src/pil_level_ctrl.sv */
// program level selection, request and internal cause logic
`timescale 1ns/1ps
module pil_level_ctrl
	import pil_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// sequencer operations
	input  wire logic        op_valid,
	input  wire logic [2:0]  op_code,
	input  wire logic [2:0]  op_sel,
	input  wire logic [15:0] acc_in,
	input  wire logic        instr_boundary,
	// request sources
	input  wire logic [15:0] ext_req,
	input  wire logic [10:0] src_event,
	input  wire logic        fetch_phase,
	// results
	output logic [15:0]      rd_data,
	output logic             rd_valid,
	output logic [3:0]       current_level,
	output logic [3:0]       previous_level,
	output logic             ctx_switch,
	output logic             switch_busy,
	output logic             interrupts_on,
	output logic             pc_hold,
	output logic             fetch_fault_flag
);

	////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [15:0] req;
		logic [15:0] ena;
		logic [10:0] src_en;
		logic [3:0]  cause;
		logic [3:0]  prev;
		logic [3:0]  cur;
		logic        interrupts_on_op;
		logic [15:0] rd_data;
		logic        rd_valid;
		logic        switched;
		logic        pc_hold;
		logic        fetch_flag;
		pil_state_t  st;
		logic [5:0]  cnt;
	} pil_regs_t;

	pil_regs_t   state_reg;
	pil_regs_t   state_next;

	logic        lvl_any;
	logic [3:0]  lvl_idx;
	logic        src_any;
	logic [3:0]  src_idx;
	logic [10:0] src_hit;
	logic [3:0]  target;
	logic        do_switch;

	////////////////////////////////////////////////////////////////////
	// priority encoders

	pil_prio_enc #(.W(16)) u_level_enc (
		.vec (state_reg.ena & state_reg.req),
		.any (lvl_any),
		.idx (lvl_idx)
	);

	// power fail is the top bit, so highest-bit wins gives it priority
	assign src_hit = src_event & state_reg.src_en & SRC_MASK;

	pil_prio_enc #(.W(11)) u_source_enc (
		.vec (src_hit),
		.any (src_any),
		.idx (src_idx)
	);

	// nothing active selects level zero
	assign target = lvl_any ? lvl_idx : LVL_ZERO;

	// change only between instructions, with interrupts on
	assign do_switch = (state_reg.st == ST_RUN) && state_reg.interrupts_on_op &&
		instr_boundary && !op_valid &&
		(target != state_reg.cur);

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		state_next          = state_reg;
		state_next.rd_valid = 1'b0;
		state_next.switched = 1'b0;
		state_next.pc_hold  = 1'b0;
		state_next.fetch_flag = 1'b0;

		// ops ignored during the context switch sequence
		if (op_valid && state_reg.st == ST_RUN) begin
			case (op_code)
			OP_SET: begin
				case (op_sel)
				SEL_REQUEST: state_next.req = state_reg.req | acc_in;
				SEL_ENABLE:  state_next.ena = state_reg.ena | acc_in;
				default: ;
				endcase
			end
			OP_CLEAR: begin
				case (op_sel)
				SEL_REQUEST: state_next.req = state_reg.req & ~acc_in;
				SEL_ENABLE:  state_next.ena = state_reg.ena & ~acc_in;
				default: ;
				endcase
			end
			OP_WRITE: begin
				case (op_sel)
				SEL_REQUEST: state_next.req = acc_in;
				SEL_ENABLE:  state_next.ena = acc_in;
				SEL_SOURCE:  state_next.src_en = acc_in[10:0];
				default: ;
				endcase
			end
			OP_READ: begin
				state_next.rd_valid = 1'b1;
				case (op_sel)
				SEL_REQUEST: state_next.rd_data = state_reg.req;
				SEL_ENABLE:  state_next.rd_data = state_reg.ena;
				SEL_CAUSE: begin
					state_next.rd_data = {12'h000, state_reg.cause};
					state_next.cause   = RST_CAUSE;
				end
				SEL_PREV: begin
					state_next.rd_data = IRR_BASE |
						(16'(state_reg.prev) << PREV_LSB);
				end
				default: state_next.rd_data = 16'h0000;
				endcase
			end
			OP_WAIT: state_next.req[state_reg.cur] = 1'b0;
			OP_ION:  state_next.interrupts_on_op = 1'b1;
			OP_IOF:  state_next.interrupts_on_op = 1'b0;
			default: ;
			endcase
		end

		// hardware sets come last so they win over a same-cycle clear
		state_next.req = state_next.req | (ext_req & EXT_REQ_MASK);

		if (src_any) begin
			state_next.cause = src_idx;
			state_next.req[LVL_INTERNAL] = 1'b1;
			// fetch-time faults leave the program counter unadvanced
			state_next.pc_hold = fetch_phase &&
				(src_idx == 4'(SRC_NOADDR) ||
				 src_idx == 4'(SRC_PAGE) ||
				 src_idx == 4'(SRC_PROTECT));
			state_next.fetch_flag = fetch_phase &&
				(src_idx == 4'(SRC_PAGE) ||
				 src_idx == 4'(SRC_PROTECT));
		end

		case (state_reg.st)
		ST_RUN: begin
			if (do_switch) begin
				state_next.cur      = target;
				state_next.switched = 1'b1;
				state_next.st       = ST_SWITCH;
				state_next.cnt      = 6'h01;
				if (target == LVL_INTERNAL && state_reg.cur < LVL_INTERNAL)
					state_next.prev = state_reg.cur;
			end
		end
		ST_SWITCH: begin
			// the new register set is ready after the full switch time
			if (state_reg.cnt >= SWITCH_CYC) begin
				state_next.st  = ST_RUN;
				state_next.cnt = 6'h00;
			end else begin
				state_next.cnt = state_reg.cnt + 6'h01;
			end
		end
		default: begin
			state_next.st  = ST_RUN;
			state_next.cnt = 6'h00;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg.req        <= RST_REQ;
			state_reg.ena        <= RST_ENA;
			state_reg.src_en     <= RST_SRC;
			state_reg.cause      <= RST_CAUSE;
			state_reg.prev       <= RST_LEVEL;
			state_reg.cur        <= RST_LEVEL;
			state_reg.interrupts_on_op        <= 1'b0;
			state_reg.rd_data    <= 16'h0000;
			state_reg.rd_valid   <= 1'b0;
			state_reg.switched   <= 1'b0;
			state_reg.pc_hold    <= 1'b0;
			state_reg.fetch_flag <= 1'b0;
			state_reg.st         <= ST_RUN;
			state_reg.cnt        <= 6'h00;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rd_data          = state_reg.rd_data;
	assign rd_valid         = state_reg.rd_valid;
	assign current_level    = state_reg.cur;
	assign previous_level   = state_reg.prev;
	assign ctx_switch       = state_reg.switched;
	assign switch_busy      = state_reg.st[1];
	assign interrupts_on    = state_reg.interrupts_on_op;
	assign pc_hold          = state_reg.pc_hold;
	assign fetch_fault_flag = state_reg.fetch_flag;

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	logic op_run;
	assign op_run = op_valid && state_reg.st == ST_RUN;

	sequence s_switch_start;
		state_reg.st == ST_RUN && do_switch;
	endsequence

	sequence s_switch_done;
		ctx_switch ##1 switch_busy [*8];
	endsequence

	sequence s_zero_stays;
		!ctx_switch && current_level == LVL_ZERO;
	endsequence

	a_switch_target: assert property (
		s_switch_start |=> current_level == $past(target) && ctx_switch)
		else $error("level switch did not load the pending level");

	a_switch_busy: assert property (
		s_switch_start |=> s_switch_done)
		else $error("switch sequence not held busy");

	a_masked_clear: assert property (
		op_run && op_code == OP_CLEAR && op_sel == SEL_ENABLE |=>
		(state_reg.ena & $past(acc_in)) == 16'h0000)
		else $error("masked clear left a selected enable bit");

	a_masked_set: assert property (
		op_run && op_code == OP_SET && op_sel == SEL_ENABLE |=>
		(state_reg.ena & $past(acc_in)) == $past(acc_in))
		else $error("masked set missed an enable bit");

	a_ext_request: assert property (
		(ext_req & EXT_REQ_MASK) != 16'h0000 |=>
		(state_reg.req & $past(ext_req & EXT_REQ_MASK)) ==
		$past(ext_req & EXT_REQ_MASK))
		else $error("external request not latched");

	a_wait_clear: assert property (
		op_run && op_code == OP_WAIT && !src_any &&
		!ext_req[current_level] |=> !state_reg.req[$past(current_level)])
		else $error("wait did not drop running level request");

	a_off_holds: assert property (
		!interrupts_on && !switch_busy |=> $stable(current_level))
		else $error("level changed while interrupts off");

	a_internal_req: assert property (
		src_any |=> state_reg.req[LVL_INTERNAL] && state_reg.cause != 4'h0)
		else $error("internal source did not raise level 14");

	a_power_first: assert property (
		src_hit[SRC_POWER] |=> state_reg.cause == 4'(SRC_POWER))
		else $error("power fail not reported first");

	a_cause_read: assert property (
		op_run && op_code == OP_READ && op_sel == SEL_CAUSE && !src_any
		|=> rd_valid && rd_data[15:4] == 12'h000 &&
		rd_data[3:0] == $past(state_reg.cause) && state_reg.cause == 4'h0)
		else $error("cause read wrong or not cleared");

	a_prev_update: assert property (
		$changed(previous_level) |->
		current_level == LVL_INTERNAL && $past(current_level) < LVL_INTERNAL)
		else $error("previous level updated on a wrong entry");

	a_fetch_hold: assert property (
		src_any && fetch_phase && src_idx == 4'(SRC_PAGE) |=>
		pc_hold && fetch_fault_flag)
		else $error("fetch page fault did not hold the counter");

	a_ion_on: assert property (
		op_run && op_code == OP_ION |=> interrupts_on)
		else $error("interrupts-on did not take effect");

	a_iof_off: assert property (
		op_run && op_code == OP_IOF |=> !interrupts_on)
		else $error("interrupts-off did not take effect");

	a_boundary_only: assert property (
		!instr_boundary || op_valid |=> !ctx_switch)
		else $error("level change inside an instruction");

	a_set_request: assert property (
		op_run && op_code == OP_SET && op_sel == SEL_REQUEST |=>
		(state_reg.req & $past(acc_in)) == $past(acc_in))
		else $error("masked set missed a request bit");

	a_clear_request: assert property (
		op_run && op_code == OP_CLEAR && op_sel == SEL_REQUEST &&
		(ext_req & EXT_REQ_MASK) == 16'h0000 && !src_any |=>
		(state_reg.req & $past(acc_in)) == 16'h0000)
		else $error("masked clear left a selected request bit");

	a_write_enable: assert property (
		op_run && op_code == OP_WRITE && op_sel == SEL_ENABLE |=>
		state_reg.ena == $past(acc_in))
		else $error("enable write not copied");

	a_write_source: assert property (
		op_run && op_code == OP_WRITE && op_sel == SEL_SOURCE |=>
		state_reg.src_en == $past(acc_in[10:0]))
		else $error("source enable write not copied");

	a_wait_zero: assert property (
		op_run && op_code == OP_WAIT && current_level == LVL_ZERO &&
		(state_reg.ena & state_reg.req & 16'hfffe) == 16'h0000 &&
		(ext_req & EXT_REQ_MASK) == 16'h0000 && !src_any |=>
		!state_reg.req[LVL_ZERO] ##1 s_zero_stays)
		else $error("wait on level zero left level zero");

	a_prev_read: assert property (
		op_run && op_code == OP_READ && op_sel == SEL_PREV |=>
		rd_valid && rd_data[PREV_LSB +: 4] == $past(previous_level))
		else $error("previous level read misplaced");

	a_fetch_advance: assert property (
		src_any && !fetch_phase |=> !pc_hold && !fetch_fault_flag)
		else $error("counter held for a non-fetch cause");

endmodule : pil_level_ctrl

/* File: tb/pil_seq_model.sv */
// sequencer and interrupting device model for the level control
`timescale 1ns/1ps
module pil_seq_model
	import pil_pkg::*;
(
	// clock input
	input  wire logic  mclk,
	// sequencer side
	output logic        op_valid,
	output logic [2:0]  op_code,
	output logic [2:0]  op_sel,
	output logic [15:0] acc_in,
	output logic        instr_boundary,
	// interrupting devices
	output logic [15:0] ext_req,
	output logic [10:0] src_event,
	output logic        fetch_phase
);
	// idle cycles mid-instruction before an op, set by the bench
	int gap = 0;

	initial begin
		op_valid = 1'b0;
		op_code = OP_NONE;
		op_sel = SEL_REQUEST;
		acc_in = 16'h0000;
		instr_boundary = 1'b1;
		ext_req = 16'h0000;
		src_event = 11'h000;
		fetch_phase = 1'b0;
	end

	// one op, one cycle; the accumulator does not keep its last value after
	task automatic issue(input logic [2:0] c, s, input logic [15:0] a);
		repeat (gap) begin
			@(posedge mclk);
			instr_boundary <= 1'b0;
		end
		@(posedge mclk);
		instr_boundary <= 1'b1;
		op_valid <= 1'b1;
		op_code <= c;
		op_sel <= s;
		acc_in <= a;
		@(posedge mclk);
		op_valid <= 1'b0;
		op_code <= OP_NONE;
		acc_in <= ~a;
	endtask : issue

	// one-cycle device and internal status pulses
	task automatic pulse(input logic [15:0] e, input logic [10:0] s,
		input logic f);
		@(posedge mclk);
		ext_req <= e;
		src_event <= s;
		fetch_phase <= f;
		@(posedge mclk);
		ext_req <= 16'h0000;
		src_event <= 11'h000;
		fetch_phase <= 1'b0;
	endtask : pulse

	// status that stays up until the next hold_src call; reading the cause does not drop it
	task automatic hold_src(input logic [10:0] s);
		@(posedge mclk);
		src_event <= s;
	endtask : hold_src
endmodule : pil_seq_model

/* File: tb/program_level_interrupt_control_test.sv */
// self-checking bench for the program level control
`timescale 1ns/1ps
module program_level_interrupt_control_test
	import pil_pkg::*;
;
	logic        mclk, rst_b;
	logic        op_valid, instr_boundary, fetch_phase;
	logic [2:0]  op_code, op_sel;
	logic [15:0] acc_in, ext_req, rd_data;
	logic [10:0] src_event;
	logic        rd_valid, ctx_switch, switch_busy, interrupts_on;
	logic        pc_hold, fetch_fault_flag;
	logic [3:0]  current_level, previous_level;
	logic [15:0] n_sw, n_hold, n_flag, n_busy;
	int          num_errors, total_checks;

	pil_level_ctrl uut (.mclk(mclk), .rst_b(rst_b), .op_valid(op_valid),
		.op_code(op_code), .op_sel(op_sel), .acc_in(acc_in),
		.instr_boundary(instr_boundary), .ext_req(ext_req),
		.src_event(src_event), .fetch_phase(fetch_phase),
		.rd_data(rd_data), .rd_valid(rd_valid),
		.current_level(current_level), .previous_level(previous_level),
		.ctx_switch(ctx_switch), .switch_busy(switch_busy),
		.interrupts_on(interrupts_on), .pc_hold(pc_hold),
		.fetch_fault_flag(fetch_fault_flag));

	pil_seq_model seq (.mclk(mclk), .op_valid(op_valid), .op_code(op_code),
		.op_sel(op_sel), .acc_in(acc_in), .instr_boundary(instr_boundary),
		.ext_req(ext_req), .src_event(src_event),
		.fetch_phase(fetch_phase));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// pulse counters, sampled mid-cycle where outputs are settled
	always @(negedge mclk) begin
		n_sw <= n_sw + 16'(ctx_switch === 1'b1);
		n_hold <= n_hold + 16'(pc_hold === 1'b1);
		n_flag <= n_flag + 16'(fetch_fault_flag === 1'b1);
		n_busy <= n_busy + 16'(switch_busy === 1'b1);
	end

	task automatic check(input logic [15:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic op(input logic [2:0] c, s, input logic [15:0] a);
		seq.issue(c, s, a);
	endtask : op

	task automatic rdc(input logic [2:0] s, input logic [15:0] exp);
		seq.issue(OP_READ, s, 16'h0000);
		@(negedge mclk);
		check({15'h0000, rd_valid}, 16'h0001);
		check(rd_data, exp);
	endtask : rdc

	// bounded wait for any level change to finish
	task automatic settle;
		repeat (4) @(negedge mclk);
		for (int k = 0; k < 100 && switch_busy !== 1'b0; k++)
			@(negedge mclk);
		repeat (2) @(negedge mclk);
	endtask : settle

	task automatic tally_and_finish;
		$display("errors=%0d checks=%0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		check(16'(current_level), 16'h0000);
		check(16'(interrupts_on), 16'h0000);
		rdc(SEL_REQUEST, 16'h0000);
		rdc(SEL_ENABLE, 16'h0000);
	endtask : t_reset

	// power-up sequence: enable, read cause, request, interrupts on last
	task automatic t_init;
		op(OP_WRITE, SEL_ENABLE, 16'h0101);
		op(OP_WRITE, SEL_SOURCE, 16'h07fe);
		rdc(SEL_CAUSE, 16'h0000);
		op(OP_WRITE, SEL_REQUEST, 16'h0100);
		rdc(SEL_REQUEST, 16'h0100);
		check(16'(current_level), 16'h0000);
		op(OP_ION, SEL_REQUEST, 16'h0000);
		settle();
		check(16'(current_level), 16'h0008);
		op(OP_WAIT, SEL_REQUEST, 16'h0000);
		settle();
		check(16'(current_level), 16'h0000);
		op(OP_IOF, SEL_REQUEST, 16'h0000);
		op(OP_WRITE, SEL_SOURCE, 16'h0000);
		op(OP_WRITE, SEL_ENABLE, 16'h0000);
	endtask : t_init

	task automatic t_regs;
		op(OP_WRITE, SEL_ENABLE, 16'h0a55);
		op(OP_SET, SEL_ENABLE, 16'h1000);
		rdc(SEL_ENABLE, 16'h1a55);
		op(OP_CLEAR, SEL_ENABLE, 16'h0055);
		rdc(SEL_ENABLE, 16'h1a00);
	endtask : t_regs

	// requests gathered while off are entered at interrupts-on
	task automatic t_ext_off;
		op(OP_WRITE, SEL_ENABLE, 16'hffff);
		seq.pulse(16'hffff, 11'h000, 1'b0);
		rdc(SEL_REQUEST, 16'hbc00);
		op(OP_CLEAR, SEL_REQUEST, 16'hdfff);
		settle();
		check(16'(current_level), 16'h0000);
		op(OP_ION, SEL_REQUEST, 16'h0000);
		settle();
		check(16'(interrupts_on), 16'h0001);
		check(16'(current_level), 16'h000d);
		op(OP_WAIT, SEL_REQUEST, 16'h0000);
		settle();
		check(16'(current_level), 16'h0000);
		rdc(SEL_REQUEST, 16'h0000);
	endtask : t_ext_off

	task automatic t_wait_zero;
		op(OP_SET, SEL_REQUEST, 16'h0001);
		op(OP_WAIT, SEL_REQUEST, 16'h0000);
		settle();
		rdc(SEL_REQUEST, 16'h0000);
		check(16'(current_level), 16'h0000);
	endtask : t_wait_zero

	// slow sequencer; a second set of a set bit must not re-enter
	task automatic t_soft;
		logic [15:0] s0, b0;
		seq.gap = 3;
		s0 = n_sw;
		b0 = n_busy;
		op(OP_SET, SEL_REQUEST, 16'h0200);
		settle();
		check(16'(current_level), 16'h0009);
		check(n_busy - b0, 16'(SWITCH_CYC));
		op(OP_SET, SEL_REQUEST, 16'h0200);
		settle();
		check(n_sw - s0, 16'h0001);
		seq.gap = 0;
	endtask : t_soft

	task automatic t_internal;
		logic [15:0] h0, f0;
		op(OP_IOF, SEL_REQUEST, 16'h0000);
		op(OP_WRITE, SEL_SOURCE, 16'h07fe);
		for (int i = 1; i <= 10; i++) begin
			seq.pulse(16'h0000, 11'(1 << i), 1'b0);
			rdc(SEL_CAUSE, 16'(i));
			rdc(SEL_CAUSE, 16'h0000);
		end
		rdc(SEL_REQUEST, 16'h4200);
		op(OP_CLEAR, SEL_REQUEST, 16'h4000);
		op(OP_WRITE, SEL_SOURCE, 16'h0000);
		seq.pulse(16'h0000, 11'h020, 1'b0);
		rdc(SEL_CAUSE, 16'h0000);
		rdc(SEL_REQUEST, 16'h0200);
		op(OP_WRITE, SEL_SOURCE, 16'h07fe);
		seq.pulse(16'h0000, 11'h408, 1'b0);
		rdc(SEL_CAUSE, 16'h000a);
		h0 = n_hold;
		f0 = n_flag;
		seq.pulse(16'h0000, 11'h008, 1'b1);
		seq.pulse(16'h0000, 11'h002, 1'b1);
		seq.pulse(16'h0000, 11'h200, 1'b1);
		repeat (3) @(negedge mclk);
		check(n_hold - h0, 16'h0002);
		check(n_flag - f0, 16'h0001);
		rdc(SEL_CAUSE, 16'h0009);
		op(OP_CLEAR, SEL_REQUEST, 16'h4000);
	endtask : t_internal

	// a standing error indicator keeps raising level 14 until cleared
	task automatic t_err;
		seq.hold_src(11'h020);
		rdc(SEL_CAUSE, 16'h0005);
		op(OP_CLEAR, SEL_REQUEST, 16'h4000);
		rdc(SEL_REQUEST, 16'h4200);
		seq.hold_src(11'h000);
		op(OP_CLEAR, SEL_REQUEST, 16'h4000);
		rdc(SEL_REQUEST, 16'h0200);
		rdc(SEL_CAUSE, 16'h0005);
		rdc(SEL_CAUSE, 16'h0000);
	endtask : t_err

	// enter 14 from 9, then from 15; only the first saves the level
	task automatic t_prev;
		op(OP_ION, SEL_REQUEST, 16'h0000);
		settle();
		seq.pulse(16'h0000, 11'h002, 1'b0);
		settle();
		check(16'(current_level), 16'h000e);
		check(16'(previous_level), 16'h0009);
		rdc(SEL_PREV, IRR_BASE | 16'h0048);
		seq.pulse(16'h8000, 11'h000, 1'b0);
		settle();
		check(16'(current_level), 16'h000f);
		op(OP_WAIT, SEL_REQUEST, 16'h0000);
		settle();
		check(16'(current_level), 16'h000e);
		check(16'(previous_level), 16'h0009);
		op(OP_WAIT, SEL_REQUEST, 16'h0000);
		settle();
		check(16'(current_level), 16'h0009);
	endtask : t_prev

	////////////////////////////////////////////////////////////////////////
	initial begin
		#(25ns * 20000);
		num_errors++;
		tally_and_finish();
	end

	initial begin
		rst_b = 1'b0;
		n_sw = 16'h0000;
		n_hold = 16'h0000;
		n_flag = 16'h0000;
		n_busy = 16'h0000;
		num_errors = 0;
		total_checks = 0;
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		@(negedge mclk);
		t_reset();
		t_init();
		t_regs();
		t_ext_off();
		t_wait_zero();
		t_soft();
		t_internal();
		t_err();
		t_prev();
		tally_and_finish();
	end
endmodule : program_level_interrupt_control_test
